// File: hdl/lvds_tx_pkg.sv
package lvds_tx_pkg;
	localparam int          ADDR_W     = 4;
	localparam int          CHANS      = 5;
	localparam int          CHAN_BITS  = 7;
	localparam int          CTRL_W     = 7;
	localparam int          SPREAD_W   = 6;
	localparam logic [3:0]  OFF_CTRL   = 4'h0;
	localparam logic [3:0]  OFF_SPREAD = 4'h4;
	localparam logic [3:0]  OFF_STATUS = 4'h8;
	// Control register fields
	localparam int          CTRL_SWAP  = 0;
	localparam int          CTRL_W8    = 1;
	localparam int          CTRL_SWING = 2;
	localparam int          CTRL_ENA   = 3;
	localparam int          CTRL_ENB   = 4;
	localparam int          CTRL_DUAL  = 5;
	localparam int          CTRL_JEIDA = 6;
	// Spread register fields
	localparam int          SP_EN      = 0;
	localparam int          SP_RATE    = 1;
	localparam int          SP_DLO     = 3;
	localparam int          SP_DHI     = 5;
	localparam logic [CTRL_W-1:0]   CTRL_RESET   = 7'h00;
	localparam logic [SPREAD_W-1:0] SPREAD_RESET = 6'h00;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	localparam logic [CHANS-1:0] CHAN_ALL = 5'h1f;
	localparam logic [CHANS-1:0] CHAN_W8  = 5'h0f;
	// Modulation rate codes and divide ratios
	localparam logic [1:0]  RATE_NONE  = 2'h0;
	localparam logic [1:0]  RATE_512   = 2'h1;
	localparam logic [1:0]  RATE_640   = 2'h2;
	localparam logic [1:0]  RATE_1024  = 2'h3;
	localparam logic [10:0] N_512      = 11'h200;
	localparam logic [10:0] N_640      = 11'h280;
	localparam logic [10:0] N_1024     = 11'h400;
	// Depth codes, depth in ppm of the reference
	localparam logic [1:0]  DLO_0625   = 2'h0;
	localparam logic [1:0]  DLO_125    = 2'h1;
	localparam logic signed [15:0] DEPTH_0625_PPM = 16'sd6250;
	localparam logic signed [15:0] DEPTH_125_PPM  = 16'sd12500;
	// Reciprocal of a quarter period, scaled by 2**RECIP_SHIFT, rounded down
	localparam int          RECIP_SHIFT = 20;
	localparam logic signed [15:0] RECIP_512  = 16'sd8192;
	localparam logic signed [15:0] RECIP_640  = 16'sd6553;
	localparam logic signed [15:0] RECIP_1024 = 16'sd4096;

	typedef logic [9:0] color_t;
	typedef struct packed {
		color_t r;
		color_t g;
		color_t b;
	} pixel_t;
	typedef struct packed {
		logic   de;
		logic   hs;
		logic   vs;
		pixel_t odd;
		pixel_t even;
	} video_in_t;
	typedef struct packed {
		logic                             drive;
		logic                             park;
		logic                             swing_350;
		logic                             clk_en;
		logic [CHANS-1:0]                 chan_en;
		logic [CHANS-1:0][CHAN_BITS-1:0]  data;
	} link_out_t;
	typedef struct packed {
		logic       enable;
		logic [1:0] rate;
		logic       depth_hi;
		logic [1:0] depth_lo;
	} ss_cfg_t;
	typedef enum logic [1:0] {
		SEL_CTRL, SEL_SPREAD, SEL_STATUS, SEL_NONE
	} sel_t;
endpackage

// File: hdl/spread_mod.sv
`timescale 1ns/10ps
module spread_mod
	import lvds_tx_pkg::*;
(
	// Clock and reset
	input  wire logic                aclk,
	input  wire logic                aresetn,
	// Configuration
	input  wire lvds_tx_pkg::ss_cfg_t cfg,
	// Modulation
	output logic signed [15:0]       offset_ppm,
	output logic                     active,
	output logic                     cfg_error
);
	logic [10:0]        phase;
	logic [10:0]        next_phase;
	logic [10:0]        period;
	logic [10:0]        quarter;
	logic signed [15:0] recip;
	logic signed [15:0] amp;
	logic signed [11:0] tri_pos;
	logic signed [41:0] prod;
	logic               legal;
	logic               run;
	logic signed [15:0] next_offset;

	always_comb
	begin
		period = N_512;
		recip  = RECIP_512;
		unique case (cfg.rate)
			RATE_512:
			begin
				period = N_512;
				recip  = RECIP_512;
			end
			RATE_640:
			begin
				period = N_640;
				recip  = RECIP_640;
			end
			RATE_1024:
			begin
				period = N_1024;
				recip  = RECIP_1024;
			end
			RATE_NONE:
			begin
				period = N_512;
				recip  = RECIP_512;
			end
		endcase
		quarter = period >> 2;
		amp = (cfg.depth_lo == DLO_125) ? DEPTH_125_PPM : DEPTH_0625_PPM;
		legal = (cfg.rate != RATE_NONE) && !cfg.depth_hi
			&& (cfg.depth_lo == DLO_0625 || cfg.depth_lo == DLO_125);
		run = cfg.enable && legal;
		// Reference is the receive clock; it must itself be unmodulated
		next_phase = (!run || phase >= period - 11'h001) ? 11'h000 : phase + 11'h001;
		// Centre spreading: triangle from -depth through +depth and back
		if (phase < (quarter << 1))
			tri_pos = 12'(phase) - 12'(quarter);
		else
			tri_pos = 12'(quarter) * 12'sd3 - 12'(phase);
		prod = 42'(tri_pos) * 42'(amp) * 42'(recip);
		next_offset = run ? 16'(prod >>> RECIP_SHIFT) : 16'sh0000;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			phase      <= 11'h000;
			offset_ppm <= 16'sh0000;
			active     <= 1'b0;
			cfg_error  <= 1'b0;
		end
		else
		begin
			phase      <= next_phase;
			offset_ppm <= next_offset;
			active     <= run;
			cfg_error  <= cfg.enable && !legal;
		end
	end

	property p_ss_idle;
		@(posedge aclk) disable iff (!aresetn)
		!cfg.enable |=> (offset_ppm == 16'sh0000) && !active;
	endproperty
	a_ss_idle: assert property (p_ss_idle) else $error("spread active while disabled");

	property p_rate_na;
		@(posedge aclk) disable iff (!aresetn)
		(cfg.enable && cfg.rate == RATE_NONE) |=> !active && cfg_error;
	endproperty
	a_rate_na: assert property (p_rate_na) else $error("rate code zero not refused");

	property p_period;
		@(posedge aclk) disable iff (!aresetn)
		(run && $past(run) && phase == period - 11'h001) |=> phase == 11'h000;
	endproperty
	a_period: assert property (p_period) else $error("modulation period wrong");

	property p_depth;
		@(posedge aclk) disable iff (!aresetn)
		active |-> (offset_ppm <= $past(amp)) && (offset_ppm >= -$past(amp));
	endproperty
	a_depth: assert property (p_depth) else $error("spread beyond selected depth");

	c_ss_peak: cover property (@(posedge aclk) disable iff (!aresetn)
		active && offset_ppm == DEPTH_125_PPM);
endmodule

// File: hdl/lvds_tx_ctrl.sv
`timescale 1ns/10ps
// What this block does
// - Single link: stream goes to link A, or link B when swap is set.
// - Dual link: odd pixels on first link, even on second; swap exchanges them.
// - Transmit swap is its own bit, independent of receive swap.
// - 8-bit width turns off channel 4 on every link.
// - One width bit serves both links, separate from receive width.
// - One swing bit picks 250mV or 350mV amplitude.
// - Link enable cleared: clock and data pairs off, parked at common mode.
// - Both link enables reset to zero.
// - Centre-spread generator modulates only while enabled.
// - Rate is reference over 512, 640 or 1024; code zero not allowed.
// - Depth 0.625 or 1.25 percent; other code pairs not allowed.
// - One resolution mode for receive and transmit: single or dual link.
// - One bit-assignment format for both links and both sides.
module lvds_tx_ctrl
	import lvds_tx_pkg::*;
(
	// Clock and reset
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	// Register bus, write
	input  wire logic [ADDR_W-1:0]        awaddr,
	input  wire logic                     awvalid,
	output logic                          awready,
	input  wire logic [31:0]              wdata,
	input  wire logic [3:0]               wstrb,
	input  wire logic                     wvalid,
	output logic                          wready,
	output logic [1:0]                    bresp,
	output logic                          bvalid,
	input  wire logic                     bready,
	// Register bus, read
	input  wire logic [ADDR_W-1:0]        araddr,
	input  wire logic                     arvalid,
	output logic                          arready,
	output logic [31:0]                   rdata,
	output logic [1:0]                    rresp,
	output logic                          rvalid,
	input  wire logic                     rready,
	// Pixel stream in
	input  wire lvds_tx_pkg::video_in_t   vin,
	// Transmit links
	output lvds_tx_pkg::link_out_t        link_a,
	output lvds_tx_pkg::link_out_t        link_b,
	// Shared with receive side
	output logic                          mode_dual_link,
	output logic                          format_jeida,
	// Spread modulation
	output logic signed [15:0]            ss_offset_ppm,
	output logic                          ss_active
);
	import lvds_tx_pkg::*;

	typedef enum logic [1:0] {
		W_IDLE = 2'b00,
		W_ADDR = 2'b01,
		W_RESP = 2'b11,
		W_DATA = 2'b10
	} wstate_t;

	wstate_t                wstate;
	wstate_t                next_wstate;
	logic [ADDR_W-1:0]      awq;
	logic [ADDR_W-1:0]      next_awq;
	logic [31:0]            wdq;
	logic [31:0]            next_wdq;
	logic                   wsq;
	logic                   next_wsq;
	logic [1:0]             next_bresp;
	logic [CTRL_W-1:0]      ctrl;
	logic [CTRL_W-1:0]      next_ctrl;
	logic [SPREAD_W-1:0]    spread;
	logic [SPREAD_W-1:0]    next_spread;
	logic                   aw_hs;
	logic                   w_hs;
	logic                   go;
	logic [ADDR_W-1:0]      wa;
	logic [31:0]            wd;
	logic                   ws;
	logic                   next_rvalid;
	logic [31:0]            next_rdata;
	logic [1:0]             next_rresp;
	logic [31:0]            status;
	logic                   ss_error;
	ss_cfg_t                ss_cfg;
	logic [CHANS-1:0][CHAN_BITS-1:0] pk_odd;
	logic [CHANS-1:0][CHAN_BITS-1:0] pk_even;
	link_out_t              next_link_a;
	link_out_t              next_link_b;

	function automatic sel_t reg_sel(input logic [ADDR_W-1:0] a);
		unique case (a)
			OFF_CTRL:   return SEL_CTRL;
			OFF_SPREAD: return SEL_SPREAD;
			OFF_STATUS: return SEL_STATUS;
			default:    return SEL_NONE;
		endcase
	endfunction

	// Returns {core6, ext2, ext2b}; VESA carries low bits first, JEIDA high
	function automatic logic [9:0] split(input color_t c, input logic w8, input logic jeida);
		logic [7:0] c8;
		c8 = c[9:2];
		if (w8)
			split = jeida ? {c8[7:2], c8[1:0], 2'h0} : {c8[5:0], c8[7:6], 2'h0};
		else
			split = jeida ? {c[9:4], c[3:2], c[1:0]} : {c[5:0], c[7:6], c[9:8]};
	endfunction

	function automatic logic [CHANS-1:0][CHAN_BITS-1:0] pack_link(input pixel_t p,
		input logic de, input logic hs, input logic vs, input logic w8, input logic jeida);
		logic [9:0] r;
		logic [9:0] g;
		logic [9:0] b;
		r = split(p.r, w8, jeida);
		g = split(p.g, w8, jeida);
		b = split(p.b, w8, jeida);
		pack_link[0] = {g[4], r[9:4]};
		pack_link[1] = {b[5:4], g[9:5]};
		pack_link[2] = {de, vs, hs, b[9:6]};
		pack_link[3] = {1'b0, b[3:2], g[3:2], r[3:2]};
		pack_link[4] = {1'b0, b[1:0], g[1:0], r[1:0]};
	endfunction

	function automatic link_out_t drive_link(input logic en, input logic w8,
		input logic swing, input logic [CHANS-1:0][CHAN_BITS-1:0] d);
		drive_link = '0;
		drive_link.park = !en;
		if (en)
		begin
			drive_link.drive     = 1'b1;
			drive_link.clk_en    = 1'b1;
			drive_link.swing_350 = swing;
			drive_link.chan_en   = w8 ? CHAN_W8 : CHAN_ALL;
			drive_link.data      = d;
		end
	endfunction

	// Register bus, write side; address and data may come in either order
	always_comb
	begin
		next_wstate = wstate;
		next_awq    = awq;
		next_wdq    = wdq;
		next_wsq    = wsq;
		next_bresp  = bresp;
		next_ctrl   = ctrl;
		next_spread = spread;
		go          = 1'b0;
		awready     = (wstate == W_IDLE) || (wstate == W_DATA);
		wready      = (wstate == W_IDLE) || (wstate == W_ADDR);
		bvalid      = (wstate == W_RESP);
		aw_hs       = awvalid && awready;
		w_hs        = wvalid && wready;
		wa          = aw_hs ? awaddr : awq;
		wd          = w_hs ? wdata : wdq;
		ws          = w_hs ? wstrb[0] : wsq;
		if (aw_hs)
			next_awq = awaddr;
		if (w_hs)
		begin
			next_wdq = wdata;
			next_wsq = wstrb[0];
		end
		unique case (wstate)
			W_IDLE:
			begin
				if (aw_hs && w_hs)
					go = 1'b1;
				else if (aw_hs)
					next_wstate = W_ADDR;
				else if (w_hs)
					next_wstate = W_DATA;
			end
			W_ADDR: go = w_hs;
			W_DATA: go = aw_hs;
			W_RESP:
			begin
				if (bready)
					next_wstate = W_IDLE;
			end
		endcase
		if (go)
		begin
			next_wstate = W_RESP;
			next_bresp  = RESP_OKAY;
			// All fields sit in byte lane 0
			unique case (reg_sel(wa))
				SEL_CTRL:
				begin
					if (ws)
						next_ctrl = wd[CTRL_W-1:0];
				end
				SEL_SPREAD:
				begin
					if (ws)
						next_spread = wd[SPREAD_W-1:0];
				end
				SEL_STATUS: next_bresp = RESP_OKAY;
				SEL_NONE:   next_bresp = RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wstate <= W_IDLE;
			awq    <= '0;
			wdq    <= 32'h0000_0000;
			wsq    <= 1'b0;
			bresp  <= RESP_OKAY;
			ctrl   <= CTRL_RESET;
			spread <= SPREAD_RESET;
		end
		else
		begin
			wstate <= next_wstate;
			awq    <= next_awq;
			wdq    <= next_wdq;
			wsq    <= next_wsq;
			bresp  <= next_bresp;
			ctrl   <= next_ctrl;
			spread <= next_spread;
		end
	end

	// Register bus, read side; one read at a time, answered next cycle
	always_comb
	begin
		status      = {28'h000_0000, link_b.drive, link_a.drive, ss_error, ss_active};
		arready     = !rvalid;
		next_rvalid = rvalid;
		next_rdata  = rdata;
		next_rresp  = rresp;
		if (rvalid && rready)
			next_rvalid = 1'b0;
		if (arvalid && arready)
		begin
			next_rvalid = 1'b1;
			next_rresp  = RESP_OKAY;
			unique case (reg_sel(araddr))
				SEL_CTRL:   next_rdata = {25'h000_0000, ctrl};
				SEL_SPREAD: next_rdata = {26'h000_0000, spread};
				SEL_STATUS: next_rdata = status;
				SEL_NONE:
				begin
					next_rdata = 32'h0000_0000;
					next_rresp = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= RESP_OKAY;
		end
		else
		begin
			rvalid <= next_rvalid;
			rdata  <= next_rdata;
			rresp  <= next_rresp;
		end
	end

	// Link routing; one register stage from stream to pins
	always_comb
	begin
		pk_odd  = pack_link(vin.odd, vin.de, vin.hs, vin.vs, ctrl[CTRL_W8], ctrl[CTRL_JEIDA]);
		pk_even = pack_link(vin.even, vin.de, vin.hs, vin.vs, ctrl[CTRL_W8], ctrl[CTRL_JEIDA]);
		if (ctrl[CTRL_DUAL])
		begin
			next_link_a = drive_link(ctrl[CTRL_ENA], ctrl[CTRL_W8], ctrl[CTRL_SWING],
				ctrl[CTRL_SWAP] ? pk_even : pk_odd);
			next_link_b = drive_link(ctrl[CTRL_ENB], ctrl[CTRL_W8], ctrl[CTRL_SWING],
				ctrl[CTRL_SWAP] ? pk_odd : pk_even);
		end
		else
		begin
			// Idle link carries zeros but still follows its own enable
			next_link_a = drive_link(ctrl[CTRL_ENA], ctrl[CTRL_W8], ctrl[CTRL_SWING],
				ctrl[CTRL_SWAP] ? '0 : pk_odd);
			next_link_b = drive_link(ctrl[CTRL_ENB], ctrl[CTRL_W8], ctrl[CTRL_SWING],
				ctrl[CTRL_SWAP] ? pk_odd : '0);
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			link_a         <= drive_link(1'b0, 1'b0, 1'b0, '0);
			link_b         <= drive_link(1'b0, 1'b0, 1'b0, '0);
			mode_dual_link <= 1'b0;
			format_jeida   <= 1'b0;
		end
		else
		begin
			link_a         <= next_link_a;
			link_b         <= next_link_b;
			mode_dual_link <= ctrl[CTRL_DUAL];
			format_jeida   <= ctrl[CTRL_JEIDA];
		end
	end

	assign ss_cfg = '{enable: spread[SP_EN], rate: spread[SP_RATE +: 2],
		depth_hi: spread[SP_DHI], depth_lo: spread[SP_DLO +: 2]};

	spread_mod u_spread (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.cfg        (ss_cfg),
		.offset_ppm (ss_offset_ppm),
		.active     (ss_active),
		.cfg_error  (ss_error)
	);

	property p_single_a;
		@(posedge aclk) disable iff (!aresetn)
		(!ctrl[CTRL_DUAL] && !ctrl[CTRL_SWAP] && ctrl[CTRL_ENA]) |=> link_a.data == $past(pk_odd);
	endproperty
	a_single_a: assert property (p_single_a) else $error("single link A wrong data");

	property p_single_b;
		@(posedge aclk) disable iff (!aresetn)
		(!ctrl[CTRL_DUAL] && ctrl[CTRL_SWAP] && ctrl[CTRL_ENB])
			|=> link_b.data == $past(pk_odd) && link_a.data == '0;
	endproperty
	a_single_b: assert property (p_single_b) else $error("single link B wrong data");

	property p_dual;
		@(posedge aclk) disable iff (!aresetn)
		(ctrl[CTRL_DUAL] && ctrl[CTRL_ENA] && ctrl[CTRL_ENB]) |=>
			link_a.data == ($past(ctrl[CTRL_SWAP]) ? $past(pk_even) : $past(pk_odd))
			&& link_b.data == ($past(ctrl[CTRL_SWAP]) ? $past(pk_odd) : $past(pk_even));
	endproperty
	a_dual: assert property (p_dual) else $error("dual link pixel order wrong");

	property p_width;
		@(posedge aclk) disable iff (!aresetn)
		(ctrl[CTRL_ENA] && ctrl[CTRL_ENB])
			|=> link_a.chan_en[4] == !$past(ctrl[CTRL_W8]) && link_b.chan_en == link_a.chan_en;
	endproperty
	a_width: assert property (p_width) else $error("channel 4 not per width");

	property p_swing;
		@(posedge aclk) disable iff (!aresetn)
		ctrl[CTRL_ENA] |=> link_a.swing_350 == $past(ctrl[CTRL_SWING]);
	endproperty
	a_swing: assert property (p_swing) else $error("swing select not applied");

	property p_park;
		@(posedge aclk) disable iff (!aresetn)
		!ctrl[CTRL_ENB] |=> link_b.park && !link_b.drive && !link_b.clk_en
			&& link_b.chan_en == '0 && link_b.data == '0;
	endproperty
	a_park: assert property (p_park) else $error("disabled link not parked");

	property p_reset_off;
		@(posedge aclk) !aresetn |=> !link_a.drive && !link_b.drive && link_a.park;
	endproperty
	a_reset_off: assert property (p_reset_off) else $error("links driven after reset");

	property p_shared;
		@(posedge aclk) disable iff (!aresetn)
		1'b1 |=> mode_dual_link == $past(ctrl[CTRL_DUAL]) && format_jeida == $past(ctrl[CTRL_JEIDA]);
	endproperty
	a_shared: assert property (p_shared) else $error("shared mode not forwarded");

	c_dual_swap: cover property (@(posedge aclk) disable iff (!aresetn)
		ctrl[CTRL_DUAL] && ctrl[CTRL_SWAP] && link_a.drive && link_b.drive);
	c_single_b: cover property (@(posedge aclk) disable iff (!aresetn)
		!ctrl[CTRL_DUAL] && ctrl[CTRL_SWAP] && link_b.drive);
	c_w8: cover property (@(posedge aclk) disable iff (!aresetn)
		link_a.drive && link_a.chan_en == CHAN_W8);
endmodule

// File: tb/panel_model.sv
`timescale 1ns/10ps
module panel_model
	import lvds_tx_pkg::*;
(
	// Clock
	input  wire logic                   aclk,
	// Links from the transmitter
	input  wire lvds_tx_pkg::link_out_t link_a,
	input  wire lvds_tx_pkg::link_out_t link_b,
	// Words the panel decodes
	output logic [34:0]                 seen_a,
	output logic [34:0]                 seen_b
);
	// A parked pair carries nothing; toggle so stale data never matches
	always_ff @(posedge aclk)
	begin
		seen_a <= (link_a.drive && !link_a.park) ? link_a.data : ~seen_a;
		seen_b <= (link_b.drive && !link_b.park) ? link_b.data : ~seen_b;
	end
endmodule

// File: tb/lvds_tx_ctrl_test.sv
`timescale 1ns/10ps
module lvds_tx_ctrl_test;
	import lvds_tx_pkg::*;
	logic              aclk = 1'b0;
	logic              aresetn = 1'b0;
	logic [ADDR_W-1:0] awaddr = '0;
	logic [ADDR_W-1:0] araddr = '0;
	logic              awvalid = 1'b0;
	logic              wvalid = 1'b0;
	logic              bready = 1'b0;
	logic              arvalid = 1'b0;
	logic              rready = 1'b0;
	logic [31:0]       wdata = '0;
	logic [3:0]        wstrb = '0;
	logic              awready, wready, bvalid, arready, rvalid;
	logic [1:0]        bresp, rresp;
	logic [31:0]       rdata;
	video_in_t         vin = '0;
	link_out_t         link_a, link_b;
	logic              mode_dual_link, format_jeida, ss_active;
	logic signed [15:0] ss_offset_ppm;
	logic [34:0]       seen_a, seen_b;
	int                failures = 0;
	int                comparisons = 0;
	logic [6:0]        modes [8] = '{7'h08, 7'h19, 7'h38, 7'h39, 7'h7e, 7'h4f, 7'h10, 7'h00};
	logic [5:0]        bad [4] = '{6'h01, 6'h23, 6'h13, 6'h1b};

	// Receive clock is a clean fixed period and never spread
	always #2 aclk = ~aclk;

	lvds_tx_ctrl dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.vin(vin), .link_a(link_a), .link_b(link_b), .mode_dual_link(mode_dual_link),
		.format_jeida(format_jeida), .ss_offset_ppm(ss_offset_ppm), .ss_active(ss_active));

	panel_model panel_u (.aclk(aclk), .link_a(link_a), .link_b(link_b),
		.seen_a(seen_a), .seen_b(seen_b));

	task automatic print_verdict;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		n = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end
		while (!bvalid && n < 40);
		bready <= 1'b0;
		chk({62'h0, bresp}, {62'h0, er});
		if (n >= 40) failures++;
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		@(posedge aclk);
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
		end
		while (!rvalid && n < 40);
		rready <= 1'b0;
		chk({32'h0, rdata}, {32'h0, ed});
		chk({62'h0, rresp}, {62'h0, er});
		if (n >= 40) failures++;
	endtask

	// Seven-bit channel words of one pixel, sync bits ride on channel 2
	function automatic logic [34:0] pack(input pixel_t p, input logic w8, input logic j);
		color_t     x [3];
		logic [5:0] co [3];
		logic [1:0] e1 [3];
		logic [1:0] e2 [3];
		logic [7:0] c8;
		x[0] = p.r;
		x[1] = p.g;
		x[2] = p.b;
		for (int i = 0; i < 3; i++)
		begin
			c8 = x[i][9:2];
			co[i] = w8 ? (j ? c8[7:2] : c8[5:0]) : (j ? x[i][9:4] : x[i][5:0]);
			e1[i] = w8 ? (j ? c8[1:0] : c8[7:6]) : (j ? x[i][3:2] : x[i][7:6]);
			e2[i] = w8 ? 2'h0 : (j ? x[i][1:0] : x[i][9:8]);
		end
		return {1'b0, e2[2], e2[1], e2[0], 1'b0, e1[2], e1[1], e1[0], vin.de, vin.vs, vin.hs,
			co[2][5:2], co[2][1:0], co[1][5:1], co[1][0], co[0]};
	endfunction

	task automatic check_links(input logic [6:0] c);
		logic [34:0] po, pe, ea, eb;
		po = pack(vin.odd, c[CTRL_W8], c[CTRL_JEIDA]);
		pe = pack(vin.even, c[CTRL_W8], c[CTRL_JEIDA]);
		ea = !c[CTRL_ENA] ? '0 : c[CTRL_DUAL] ? (c[CTRL_SWAP] ? pe : po) : (c[CTRL_SWAP] ? '0 : po);
		eb = !c[CTRL_ENB] ? '0 : c[CTRL_DUAL] ? (c[CTRL_SWAP] ? po : pe) : (c[CTRL_SWAP] ? po : '0);
		chk(64'(link_a.data), 64'(ea));
		chk(64'(link_b.data), 64'(eb));
		chk({link_a.drive, link_a.park, link_a.clk_en, link_a.chan_en}, {c[CTRL_ENA], !c[CTRL_ENA],
			c[CTRL_ENA], c[CTRL_ENA] ? (c[CTRL_W8] ? CHAN_W8 : CHAN_ALL) : 5'h0});
		chk({link_b.drive, link_b.park, link_b.clk_en, link_b.chan_en}, {c[CTRL_ENB], !c[CTRL_ENB],
			c[CTRL_ENB], c[CTRL_ENB] ? (c[CTRL_W8] ? CHAN_W8 : CHAN_ALL) : 5'h0});
		if (c[CTRL_ENA]) chk(link_a.swing_350, c[CTRL_SWING]);
		if (c[CTRL_ENB]) chk(link_b.swing_350, c[CTRL_SWING]);
		chk({mode_dual_link, format_jeida}, {c[CTRL_DUAL], c[CTRL_JEIDA]});
		@(posedge aclk);
		#1;
		if (c[CTRL_ENB]) chk(seen_b, eb);
	endtask

	// Rate from the spacing of the deepest point, depth from the extremes
	task automatic spread_run(input logic [5:0] cfg, input int n, input logic signed [15:0] dep,
		input logic exact);
		logic signed [15:0] mn, mx;
		int first, second;
		wr(OFF_SPREAD, {26'h0, cfg}, RESP_OKAY);
		@(posedge aclk);
		#1;
		chk(ss_active, 1'b1);
		mn = 16'sd32767;
		mx = -16'sd32767;
		first = 0;
		second = 0;
		for (int i = 1; i <= 2 * n + 4; i++)
		begin
			@(posedge aclk);
			if (ss_offset_ppm < mn)
			begin
				mn = ss_offset_ppm;
				first = i;
				second = 0;
			end
			else if (ss_offset_ppm == mn && second == 0) second = i;
			if (ss_offset_ppm > mx) mx = ss_offset_ppm;
		end
		chk(64'(second - first), 64'(n));
		if (exact) chk({mx, mn}, {dep, -dep});
		else chk({mx <= dep, mn >= -dep}, 2'h3);
	endtask

	initial
	begin
		#100000;
		failures++;
		print_verdict;
	end

	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		#1;
		chk({link_a.drive, link_a.park, link_b.drive, link_b.park, ss_active}, 5'h0a);
		rd(OFF_CTRL, 32'h0, RESP_OKAY);
		rd(OFF_SPREAD, 32'h0, RESP_OKAY);
		rd(OFF_STATUS, 32'h0, RESP_OKAY);
		wr(4'hc, 32'h7f, RESP_SLVERR);
		rd(4'hc, 32'h0, RESP_SLVERR);
		wr(OFF_STATUS, 32'hf, RESP_OKAY);
		rd(OFF_STATUS, 32'h0, RESP_OKAY);
		wr(OFF_CTRL, 32'hffffffff, RESP_OKAY);
		rd(OFF_CTRL, 32'h7f, RESP_OKAY);
		rd(OFF_STATUS, 32'hc, RESP_OKAY);
		wr(OFF_CTRL, 32'h0, RESP_OKAY);
		wr(OFF_SPREAD, 32'h2, RESP_OKAY);
		repeat (3) @(posedge aclk);
		#1;
		chk({ss_active, ss_offset_ppm}, 17'h0);
		foreach (bad[i])
		begin
			wr(OFF_SPREAD, {26'h0, bad[i]}, RESP_OKAY);
			repeat (2) @(posedge aclk);
			#1;
			chk({ss_active, ss_offset_ppm}, 17'h0);
			rd(OFF_STATUS, 32'h2, RESP_OKAY);
		end
		rd(OFF_SPREAD, 32'h1b, RESP_OKAY);
		spread_run(6'h03, 512, DEPTH_0625_PPM, 1'b1);
		spread_run(6'h0d, 640, DEPTH_125_PPM, 1'b0);
		spread_run(6'h0f, 1024, DEPTH_125_PPM, 1'b1);
		rd(OFF_STATUS, 32'h1, RESP_OKAY);
		wr(OFF_SPREAD, 32'h0, RESP_OKAY);
		for (int i = 0; i < 8; i++)
		begin
			wr(OFF_CTRL, {25'h0, modes[i]}, RESP_OKAY);
			vin.odd <= 30'h2a54f3c9 ^ 30'(i * 7919);
			vin.even <= 30'h15ab0c36 ^ 30'(i * 104729);
			{vin.de, vin.hs, vin.vs} <= 3'(i + 5);
			repeat (2) @(posedge aclk);
			#1;
			check_links(modes[i]);
		end
		print_verdict;
	end
endmodule
